//--- pml_top.sv
// Port mode and link monitor top: hot-plug defaults, port configuration, status
// Contract
// - An inserted glass fiber module on an unconfigured system sets its ports to 100 Mbps full duplex, monitoring off.
// - A module inserted into an already configured system keeps the stored configuration.
// - Removing or replacing a glass fiber module returns its ports to auto negotiation.
// - Module insertion and removal are detected live and reported to management.
// - A port without link test pulses, unused or facing a powered-down partner, is a cable interrupt.
// - A glass fiber port flags a far end fault when the partner reports no link.
// - The copper plus polymer module defaults to auto negotiation on both ports, crossing on copper, no monitoring.
// - Auto negotiation takes speed and duplex from the partner and applies them unaided.
// - Auto negotiation is enabled or disabled per port by a management-writable setting.
// - The copper port swaps its pairs automatically so either cable type works.
// - Pair crossing is active only while auto negotiation is enabled on the port.
// - The copper receiver corrects an inverted receive pair automatically.
// - Copper ports are watched for shorts and interrupts with periodic link test pulses.
// - The copper plus clad-silica module defaults to auto copper and fixed 100 Mbps full fiber, no monitoring.
`timescale 1ns/10ps
module pml_top
   import pml_pkg::*;
#(
   parameter int LOSS_CYC = LINK_LOSS_CYC
)(
   input  wire logic                   clk,
   input  wire logic                   nrst,
   input  wire logic [AW-1:0]          s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [AW-1:0]          s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   mod_present,
   input  wire pml_mtype_t             mod_type,
   input  wire pml_line_t [NPORT-1:0]  line_st,
   output pml_pstat_t [NPORT-1:0]      port_st,
   output pml_pcfg_t [NPORT-1:0]       port_cfg
);
   typedef struct packed {
      logic                    cfg_stored;
      pml_pcfg_t [NPORT-1:0]   pcfg;
      logic                    present;
      pml_mtype_t              mtype;
      logic                    evt_plug;
      logic [NPORT-1:0]        evt_mon;
      pml_pstat_t [NPORT-1:0]  pst;
   } pml_top_st_t;

   pml_top_st_t       st_q, st_d;
   logic [1:0]        rst_sync_q;
   logic              rst_n;
   logic              wr_pulse;
   logic [AW-1:0]     wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic [31:0]       rd_data;
   logic              plug_in;
   logic              plug_out;
   logic              wr_byte0;
   logic [NPORT-1:0]  cable_int;
   logic [NPORT-1:0]  far_fault;
   logic [NPORT-1:0]  mdix;
   logic [NPORT-1:0]  pol_inv;
   logic [NPORT-1:0]  mon_evt;

   function automatic logic pml_hit(input logic [AW-1:0] addr, input logic [AW-1:0] off);
      pml_hit = (addr[AW-1:2] == off[AW-1:2]);
   endfunction

   function automatic pml_pcfg_t pml_dflt(input pml_mtype_t t, input int p);
      case (t)
         MT_GLASS: pml_dflt = CFG_FIX100;
         MT_CLAD:  pml_dflt = (p == 1) ? CFG_FIX100 : CFG_AUTO;
         MT_POLY:  pml_dflt = CFG_AUTO;
         default:  pml_dflt = CFG_AUTO;
      endcase
   endfunction

   // Reset release through two flops
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'h1};
      end
   end
   assign rst_n = rst_sync_q[1];

   pml_axil u_axil (
      .clk           (clk),
      .rst_n         (rst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .rd_data       (rd_data),
      .wr_pulse      (wr_pulse),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb)
   );

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_port
         pml_port #(.LOSS_CYC(LOSS_CYC)) u_port (
            .clk       (clk),
            .rst_n     (rst_n),
            .line      (line_st[gp]),
            .an_en     (st_q.pcfg[gp].an_en),
            .mon_en    (st_q.pcfg[gp].mon_en),
            .is_glass  (st_q.mtype == MT_GLASS),
            .cable_int (cable_int[gp]),
            .far_fault (far_fault[gp]),
            .mdix      (mdix[gp]),
            .pol_inv   (pol_inv[gp]),
            .mon_evt   (mon_evt[gp])
         );
      end
   endgenerate

   // Read mux; unmapped words read as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      if (pml_hit(s_axi_araddr, A_CTRL)) begin
         rd_data[0] = st_q.cfg_stored;
      end
      for (int p = 0; p < NPORT; p++) begin
         if (pml_hit(s_axi_araddr, AW'(A_PCFG0 + AW'(4 * p)))) begin
            rd_data[3:0] = st_q.pcfg[p];
         end
      end
      if (pml_hit(s_axi_araddr, A_STAT)) begin
         rd_data[0]   = st_q.present;
         rd_data[3:1] = st_q.mtype;
         rd_data[4 +: 6 * NPORT] = st_q.pst;
      end
      if (pml_hit(s_axi_araddr, A_EVT)) begin
         rd_data[0]       = st_q.evt_plug;
         rd_data[NPORT:1] = st_q.evt_mon;
      end
   end

   assign plug_in  = mod_present & (~st_q.present | (mod_type != st_q.mtype));
   assign plug_out = st_q.present & (~mod_present | (mod_type != st_q.mtype));
   assign wr_byte0 = wr_pulse & wr_strb[0];

   always_comb begin
      st_d = st_q;
      if (wr_byte0 && pml_hit(wr_addr, A_CTRL)) begin
         st_d.cfg_stored = wr_data[0];
      end
      for (int p = 0; p < NPORT; p++) begin
         if (wr_byte0 && pml_hit(wr_addr, AW'(A_PCFG0 + AW'(4 * p)))) begin
            st_d.pcfg[p]    = wr_data[3:0];
            st_d.cfg_stored = 1'h1;
         end
      end
      // A departing glass or fixed-rate fiber module hands its ports back to auto
      if (plug_out && (st_q.mtype == MT_GLASS || st_q.mtype == MT_CLAD)) begin
         for (int p = 0; p < NPORT; p++) begin
            st_d.pcfg[p] = CFG_AUTO;
         end
      end
      // A stored configuration survives insertion untouched
      if (plug_in && !st_d.cfg_stored) begin
         for (int p = 0; p < NPORT; p++) begin
            st_d.pcfg[p] = pml_dflt(mod_type, p);
         end
      end
      st_d.present = mod_present;
      st_d.mtype   = mod_present ? mod_type : MT_NONE;
      // Event bits: write one to clear, a new event wins over the clear
      if (wr_byte0 && pml_hit(wr_addr, A_EVT)) begin
         st_d.evt_plug = st_q.evt_plug & ~wr_data[0];
         st_d.evt_mon  = st_q.evt_mon & ~wr_data[NPORT:1];
      end
      st_d.evt_plug = st_d.evt_plug | plug_in | plug_out;
      st_d.evt_mon  = st_d.evt_mon | mon_evt;
      for (int p = 0; p < NPORT; p++) begin
         if (!st_q.pcfg[p].an_en) begin
            st_d.pst[p].speed100 = st_q.pcfg[p].force_100;
            st_d.pst[p].full_dup = st_q.pcfg[p].force_full;
         end else if (line_st[p].an_done) begin
            st_d.pst[p].speed100 = line_st[p].an_spd100;
            st_d.pst[p].full_dup = line_st[p].an_full;
         end
         st_d.pst[p].mdix      = mdix[p];
         st_d.pst[p].pol_inv   = pol_inv[p];
         st_d.pst[p].cable_int = cable_int[p];
         st_d.pst[p].far_fault = far_fault[p];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q            <= '0;
         st_q.cfg_stored <= CFG_STORED_RST;
         st_q.pcfg       <= {NPORT{CFG_AUTO}};
         st_q.mtype      <= MT_NONE;
      end else begin
         st_q <= st_d;
      end
   end

   assign port_st  = st_q.pst;
   assign port_cfg = st_q.pcfg;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_glass_default: assert property (
      (plug_in && mod_type == MT_GLASS && !st_q.cfg_stored && !wr_pulse)
      |=> (st_q.pcfg[0] == CFG_FIX100) && (st_q.pcfg[1] == CFG_FIX100))
      else $error("glass module did not load fixed 100 full defaults");
   a_keep_config: assert property (
      (plug_in && !plug_out && st_q.cfg_stored && !wr_pulse) |=> $stable(st_q.pcfg))
      else $error("stored configuration overwritten on insertion");
   a_glass_revert: assert property (
      (plug_out && st_q.mtype == MT_GLASS && st_q.cfg_stored && !wr_pulse)
      |=> (st_q.pcfg[0] == CFG_AUTO) && (st_q.pcfg[1] == CFG_AUTO))
      else $error("ports not returned to auto after glass removal");
   a_plug_event: assert property ((plug_in || plug_out) |=> st_q.evt_plug)
      else $error("hot-plug change not reported");
   a_poly_default: assert property (
      (plug_in && mod_type == MT_POLY && !st_q.cfg_stored && !wr_pulse)
      |=> st_q.pcfg[0].an_en && st_q.pcfg[1].an_en && !st_q.pcfg[0].mon_en
          && !st_q.pcfg[1].mon_en)
      else $error("polymer module defaults wrong");
   a_clad_default: assert property (
      (plug_in && mod_type == MT_CLAD && !st_q.cfg_stored && !wr_pulse)
      |=> (st_q.pcfg[0] == CFG_AUTO) && (st_q.pcfg[1] == CFG_FIX100))
      else $error("clad-silica module defaults wrong");
   a_speed_auto: assert property (
      (st_q.pcfg[0].an_en && line_st[0].an_done)
      |=> st_q.pst[0].speed100 == $past(line_st[0].an_spd100)
          && st_q.pst[0].full_dup == $past(line_st[0].an_full))
      else $error("negotiated speed or duplex not applied");
   a_speed_forced: assert property (
      !st_q.pcfg[1].an_en
      |=> st_q.pst[1].speed100 == $past(st_q.pcfg[1].force_100)
          && st_q.pst[1].full_dup == $past(st_q.pcfg[1].force_full))
      else $error("forced speed not applied with negotiation off");

   c_glass_insert: cover property (plug_in && mod_type == MT_GLASS);
   c_cable_event: cover property (mon_evt[0] ##[1:20] st_q.evt_mon[0]);
   c_reg_write: cover property (wr_pulse && pml_hit(wr_addr, A_PCFG0));
   c_far_fault: cover property (st_q.pst[0].far_fault);
endmodule

//--- pml_pkg.sv
// Shared constants and types for the port mode and link monitor
package pml_pkg;
   localparam int          NPORT         = 2;
   localparam int          AW            = 8;
   localparam logic [7:0]  A_CTRL        = 8'h00;
   localparam logic [7:0]  A_PCFG0       = 8'h04;
   localparam logic [7:0]  A_PCFG1       = 8'h08;
   localparam logic [7:0]  A_STAT        = 8'h0C;
   localparam logic [7:0]  A_EVT         = 8'h10;
   localparam int          CLK_HZ        = 25_000_000;
   localparam int          LINK_LOSS_MS  = 100;
   localparam int          LINK_LOSS_CYC = LINK_LOSS_MS * (CLK_HZ / 1000);
   localparam logic        CFG_STORED_RST = 1'h0;

   typedef enum logic [2:0] {
      MT_NONE  = 3'b000,
      MT_GLASS = 3'b001,
      MT_POLY  = 3'b010,
      MT_CLAD  = 3'b011,
      MT_OTHER = 3'b100
   } pml_mtype_t;

   typedef struct packed {
      logic an_en;
      logic force_100;
      logic force_full;
      logic mon_en;
   } pml_pcfg_t;

   localparam pml_pcfg_t CFG_AUTO    = 4'h8;
   localparam pml_pcfg_t CFG_FIX100  = 4'h6;

   typedef struct packed {
      logic lp_pulse;
      logic short_det;
      logic rx_inv;
      logic pair_swap;
      logic far_nolink;
      logic an_done;
      logic an_spd100;
      logic an_full;
   } pml_line_t;

   typedef struct packed {
      logic speed100;
      logic full_dup;
      logic mdix;
      logic pol_inv;
      logic cable_int;
      logic far_fault;
   } pml_pstat_t;
endpackage

//--- pml_axil.sv
// AXI4-Lite slave front end producing a one-cycle register write strobe
`timescale 1ns/10ps
module pml_axil
   import pml_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   input  wire logic [31:0]   rd_data,
   output logic               wr_pulse,
   output logic [AW-1:0]      wr_addr,
   output logic [31:0]        wr_data,
   output logic [3:0]         wr_strb
);
   typedef struct packed {
      logic          aw_ok;
      logic [AW-1:0] addr;
      logic          w_ok;
      logic [31:0]   data;
      logic [3:0]    strb;
      logic          awready;
      logic          wready;
      logic          bvalid;
      logic          arready;
      logic          rvalid;
      logic [31:0]   rdata;
   } pml_axs_t;

   pml_axs_t st_q, st_d;

   always_comb begin
      st_d = st_q;
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_ok = 1'h1;
         st_d.addr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_ok = 1'h1;
         st_d.data = s_axi_wdata;
         st_d.strb = s_axi_wstrb;
      end
      // Both halves held: the write lands now and the response follows
      if (st_q.aw_ok && st_q.w_ok && !st_q.bvalid) begin
         st_d.aw_ok  = 1'h0;
         st_d.w_ok   = 1'h0;
         st_d.bvalid = 1'h1;
      end else if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'h0;
      end
      if (s_axi_arvalid && st_q.arready) begin
         st_d.rvalid = 1'h1;
         st_d.rdata  = rd_data;
      end else if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'h0;
      end
      st_d.awready = ~st_d.aw_ok & ~st_d.bvalid;
      st_d.wready  = ~st_d.w_ok & ~st_d.bvalid;
      st_d.arready = ~st_d.rvalid;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign wr_pulse      = st_q.aw_ok & st_q.w_ok & ~st_q.bvalid;
   assign wr_addr       = st_q.addr;
   assign wr_data       = st_q.data;
   assign wr_strb       = st_q.strb;
   assign s_axi_awready = st_q.awready;
   assign s_axi_wready  = st_q.wready;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = 2'h0;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = st_q.rdata;
   assign s_axi_rresp   = 2'h0;
endmodule

//--- pml_port.sv
// Per-port line supervision: link pulse watchdog, far end fault, crossing, polarity
`timescale 1ns/10ps
module pml_port
   import pml_pkg::*;
#(
   parameter int LOSS_CYC = LINK_LOSS_CYC
)(
   input  wire logic      clk,
   input  wire logic      rst_n,
   input  wire pml_line_t line,
   input  wire logic      an_en,
   input  wire logic      mon_en,
   input  wire logic      is_glass,
   output logic           cable_int,
   output logic           far_fault,
   output logic           mdix,
   output logic           pol_inv,
   output logic           mon_evt
);
   localparam int CW = $clog2(LOSS_CYC + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          cable_int;
      logic          far_fault;
      logic          mdix;
      logic          pol_inv;
      logic          mon_evt;
   } pml_pst_t;

   pml_pst_t st_q, st_d;

   always_comb begin
      st_d = st_q;
      // Silence for the loss time, or a shorted pair, counts as an interrupt
      if (line.lp_pulse) begin
         st_d.cnt       = '0;
         st_d.cable_int = line.short_det;
      end else if (st_q.cnt == CW'(LOSS_CYC - 1)) begin
         st_d.cable_int = 1'h1;
      end else begin
         st_d.cnt       = st_q.cnt + CW'(1);
         st_d.cable_int = st_q.cable_int | line.short_det;
      end
      st_d.far_fault = is_glass & ~st_d.cable_int & line.far_nolink;
      st_d.mdix      = an_en & line.pair_swap;
      if (st_d.cable_int) begin
         st_d.pol_inv = 1'h0;
      end else if (line.lp_pulse) begin
         st_d.pol_inv = line.rx_inv;
      end
      st_d.mon_evt = mon_en & ((st_d.cable_int ^ st_q.cable_int)
                               | (st_d.far_fault ^ st_q.far_fault));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q           <= '0;
         st_q.cable_int <= 1'h1;
      end else begin
         st_q <= st_d;
      end
   end

   assign cable_int = st_q.cable_int;
   assign far_fault = st_q.far_fault;
   assign mdix      = st_q.mdix;
   assign pol_inv   = st_q.pol_inv;
   assign mon_evt   = st_q.mon_evt;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_loss_timeout: assert property (
      (st_q.cnt == CW'(LOSS_CYC - 1) && !line.lp_pulse) |=> cable_int)
      else $error("no interrupt after link pulse timeout");
   a_mdix_gated: assert property (!an_en |=> !mdix)
      else $error("crossing active without auto negotiation");
   a_far_glass: assert property (far_fault |-> $past(is_glass) && !cable_int)
      else $error("far end fault outside a healthy glass port");
   a_mon_event: assert property (
      (mon_en && $changed(st_d.cable_int)) |=> mon_evt ##1 !mon_evt || $changed(cable_int))
      else $error("missing monitor event on cable change");
endmodule

//--- pml_lp.sv
// Remote link partner model: link test pulses and negotiated abilities
`timescale 1ns/10ps
module pml_lp
   import pml_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      alive,
   input  wire pml_line_t ctl,
   output pml_line_t      line
);
   logic [1:0] cnt_q = 2'h0;
   // Free-running pulse spacing; the model has no reset of its own
   always @(posedge clk) begin
      cnt_q <= cnt_q + 2'h1;
   end
   // A powered-down partner sends no pulses
   always_comb begin
      line          = ctl;
      line.lp_pulse = alive && (cnt_q == 2'h0);
   end
endmodule

//--- tb.sv
// Self-checking bench for the port mode and link monitor
`timescale 1ns/10ps
module tb
   import pml_pkg::*;
   ;
   localparam int LC = 16;
   localparam logic [7:0] DEF [4] = '{8'h66, 8'h88, 8'h68, 8'h88};
   logic clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, mod_present, alive0, alive1;
   logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   pml_mtype_t mod_type;
   pml_line_t ctl0, ctl1;
   wire pml_line_t [NPORT-1:0] line_st;
   pml_pstat_t [NPORT-1:0] port_st;
   pml_pcfg_t [NPORT-1:0] port_cfg;
   int bad_count, compares, tmo;
   pml_top #(.LOSS_CYC(LC)) dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .mod_present, .mod_type, .line_st, .port_st, .port_cfg);
   pml_lp lp0 (.clk, .alive(alive0), .ctl(ctl0), .line(line_st[0]));
   pml_lp lp1 (.clk, .alive(alive1), .ctl(ctl1), .line(line_st[1]));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      tmo++;
      if (tmo == 5000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      chk({6'h00, s_axi_bresp}, 8'h00);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      chk({6'h00, s_axi_rresp}, 8'h00);
      chk(s_axi_rdata[7:0], e);
   endtask
   initial begin
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, mod_present, alive0, alive1, ctl0, ctl1} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, bad_count, compares, tmo} = '0;
      s_axi_wstrb = 4'hF;
      mod_type = MT_NONE;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      cyc(4);
      chk(port_cfg, 8'h88);
      chk({2'h0, port_st[0]}, 8'h02);
      rc(A_CTRL, 8'h00);
      wr(8'h20, 32'h0000_00FF);
      rc(8'h20, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         mod_type <= pml_mtype_t'(i + 1);
         mod_present <= 1'b1;
         cyc(3);
         chk(port_cfg, DEF[i]);
         rc(A_EVT, 8'h01);
         wr(A_EVT, 32'h0000_0001);
         mod_present <= 1'b0;
         mod_type <= MT_NONE;
         cyc(3);
         chk(port_cfg, 8'h88);
      end
      rc(A_EVT, 8'h01);
      wr(A_EVT, 32'h0000_0001);
      rc(A_EVT, 8'h00);
      $display("hot plug test done");
      wr(A_CTRL, 32'h0000_0001);
      mod_type <= MT_GLASS;
      mod_present <= 1'b1;
      alive1 <= 1'b1;
      ctl1.far_nolink <= 1'b1;
      cyc(LC);
      chk(port_cfg, 8'h88);
      rc(A_STAT, 8'h23);
      chk({2'h0, port_st[1]} & 8'h03, 8'h01);
      alive1 <= 1'b0;
      cyc(2 * LC + 4);
      chk({2'h0, port_st[1]} & 8'h03, 8'h02);
      rc(A_EVT, 8'h01);
      mod_present <= 1'b0;
      mod_type <= MT_NONE;
      cyc(3);
      chk(port_cfg, 8'h88);
      wr(A_EVT, 32'h0000_0001);
      $display("glass test done");
      ctl0 <= 8'h35;
      alive0 <= 1'b1;
      cyc(LC);
      chk({2'h0, port_st[0]}, 8'h1C);
      ctl0.an_spd100 <= 1'b1;
      ctl0.an_full <= 1'b0;
      cyc(3);
      chk({2'h0, port_st[0]}, 8'h2C);
      wr(A_PCFG0, 32'h0000_0006);
      cyc(2);
      chk({2'h0, port_st[0]}, 8'h34);
      rc(A_PCFG0, 8'h06);
      wr(A_PCFG0, 32'h0000_0001);
      cyc(2);
      chk({2'h0, port_st[0]}, 8'h04);
      alive0 <= 1'b0;
      cyc(2 * LC + 4);
      chk({2'h0, port_st[0]}, 8'h02);
      rc(A_EVT, 8'h02);
      $display("copper test done");
      end_of_test();
   end
endmodule
